// ### hdl/amc_map.svh
// Constants of the converter configuration front end.
// Assumes a 50 MHz system clock; included by the receiver and top modules.
`ifndef AMC_MAP_SVH
`define AMC_MAP_SVH
// System clock rate
`define AMC_CLK_MHZ 50
// Shortest hardware init pulse and the count it needs
`define AMC_INIT_MIN_NS 10
`define AMC_INIT_MIN_CYC ((`AMC_INIT_MIN_NS*`AMC_CLK_MHZ+999)/1000)
// High time after which the reset pin means parallel mode
`define AMC_PAR_HOLD_NS 1000
`define AMC_PAR_HOLD_CYC ((`AMC_PAR_HOLD_NS*`AMC_CLK_MHZ+999)/1000)
// Global control register and its bits
`define AMC_REG_GLOBAL 8'h00
`define AMC_GC_INIT 7
`define AMC_GC_RDBK 0
// Bit count of the last bit of a serial word
`define AMC_RX_LAST 4'hF
// Quantised levels of the multi-level pins
`define AMC_LVL_ZERO 2'h0
`define AMC_LVL_3_8 2'h1
`define AMC_LVL_5_8 2'h2
`define AMC_LVL_FULL 2'h3
// Mode pin codes, pin 1 in the high bit
`define AMC_MP_NORMAL 3'h0
`define AMC_MP_NS_B 3'h1
`define AMC_MP_NS_A 3'h2
`define AMC_MP_NS_AB 3'h3
`define AMC_MP_PDN 3'h4
`define AMC_MP_STBY_B 3'h5
// Serial mode reference and format: internal ref, binary, LVDS
`define AMC_CFG_DEFAULT 7'h40
`endif

// ### hdl/amc_pkg.sv
// Types of the converter configuration front end.
// Assumes amc_map.svh for the numbers; holds no logic.
package amc_pkg;
   // Where the configuration comes from
   typedef enum logic {AMC_PAR, AMC_SER} amc_mode_t;
   // One serial word, address sent first
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } amc_word_t;
   // Decoded device configuration
   typedef struct packed {
      logic int_ref;
      logic twos_fmt;
      logic cmos_out;
      logic ns_a;
      logic ns_b;
      logic pwr_down;
      logic stby_b;
   } amc_cfg_t;
   // Serial receiver state
   typedef struct packed {
      logic [2:0] m1;
      logic [2:0] m2;
      logic sclk_d;
      logic [3:0] cnt;
      logic [15:0] sh;
      logic vld;
      amc_word_t word;
   } amc_rx_st_t;
   // Top level state
   typedef struct packed {
      logic rst_m;
      logic rst_s;
      logic [2:0] mp_m;
      logic [2:0] mp_s;
      logic [1:0] sl_m;
      logic [1:0] sl_s;
      logic [1:0] pl_m;
      logic [1:0] pl_s;
      logic [7:0] hi_cnt;
      amc_mode_t mode;
      logic rdbk;
      logic init;
      logic wr;
      amc_word_t word;
      amc_cfg_t cfg;
   } amc_top_st_t;
endpackage

// ### hdl/amc_serial_rx.sv
// Serial word receiver of the configuration port.
// Pins are asynchronous; the shift clock is sampled, not used as clock.
`timescale 1ns/1ns
`include "amc_map.svh"
module amc_serial_rx (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Receiver enable from the mode logic
   input wire logic en_i,
   // Serial pins
   input wire logic port_select_low_i,
   input wire logic shift_clk_i,
   input wire logic shift_data_pin_i,
   // Received word
   output logic word_vld_o,
   output amc_pkg::amc_word_t word_o
);
   amc_pkg::amc_rx_st_t st_reg;
   amc_pkg::amc_rx_st_t st_next;
   logic fall;

   // Falling edge of the synchronised shift clock
   // Any rate works while each phase spans one of our clocks
   assign fall = st_reg.sclk_d && !st_reg.m2[1];

   // Next state: sync, shift, commit
   always_comb begin
      st_next = st_reg;
      st_next.m1 = {port_select_low_i, shift_clk_i, shift_data_pin_i};
      st_next.m2 = st_reg.m1;
      st_next.sclk_d = st_reg.m2[1];
      st_next.vld = 1'b0;
      if (!en_i || st_reg.m2[2]) begin
         st_next.cnt = '0; // Partial word dropped
      end else if (fall) begin
         // Data rides the same sync delay as the clock
         st_next.sh = {st_reg.sh[14:0], st_reg.m2[0]};
         st_next.cnt = st_reg.cnt + 4'h1;
         if (st_reg.cnt == `AMC_RX_LAST) begin
            st_next.vld = 1'b1;
            // MSB first, address byte leads
            st_next.word = {st_reg.sh[14:0], st_reg.m2[0]};
         end
      end
   end

   // State register; sync reset
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign word_vld_o = st_reg.vld;
   assign word_o = st_reg.word;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   property p_commit_16;
      word_vld_o |-> $past(st_reg.cnt) == `AMC_RX_LAST && st_reg.cnt == '0;
   endproperty
   a_commit_16: assert property (p_commit_16)
      else $error("word committed off the 16th edge");
   property p_discard;
      st_reg.m2[2] |=> st_reg.cnt == '0 && !word_vld_o;
   endproperty
   a_discard: assert property (p_discard)
      else $error("bit count kept while select high");
   property p_hold_high;
      st_reg.m2[2] |=> $stable(st_reg.sh);
   endproperty
   a_hold_high: assert property (p_hold_high)
      else $error("shift while select high");
   property p_addr_first;
      word_vld_o |-> word_o.addr == $past(st_reg.sh[14:7]);
   endproperty
   a_addr_first: assert property (p_addr_first)
      else $error("address not from first bits");
   c_two_words: cover property (word_vld_o ##[1:400] word_vld_o);
endmodule

// ### hdl/amc_cfg_top.sv
// Mode selection and configuration decode of a dual channel converter.
// Level pins arrive as comparator codes; all pins are asynchronous.
//
// Contract
// - Clock pin: extreme levels internal reference, middle levels external.
// - Select pin levels choose number format and output interface.
// - Mode pins pick noise shaping, power down or channel B standby.
// - Combined mode: mode pins configure, other three pins form port.
// - Bits shift in on falling clock edges only while select low.
// - Every sixteenth falling edge commits the word; words may chain.
// - A trailing partial word at select high is discarded.
// - First eight bits are address, last eight are data.
// - Shift clock at most 20 MHz, any slower rate and duty; the receiver misses any phase not spanning one 20 ns system clock.
// - A reset pin pulse over 10 ns restores register defaults.
// - Writing bit 7 of register 0 initialises and self clears.
// - Readback pin driven low while readback mode is off.
`timescale 1ns/1ns
`include "amc_map.svh"
module amc_cfg_top #(
   parameter logic [7:0] PAR_HOLD_CYC = 8'(`AMC_PAR_HOLD_CYC)
) (
   // Clock and reset
   input wire logic SYS_CLK_I,
   input wire logic NRST_I,
   // Reset and mode pins
   input wire logic RST_PIN_I,
   input wire logic MODE_PIN_1_I,
   input wire logic MODE_PIN_2_I,
   input wire logic MODE_PIN_3_I,
   // Serial port pins
   input wire logic PORT_SELECT_LOW_I,
   input wire logic SHIFT_CLK_I,
   input wire logic SHIFT_DATA_PIN_I,
   // Comparator codes of the level pins
   input wire logic [1:0] SHIFT_CLK_LVL_I,
   input wire logic [1:0] PORT_SELECT_LVL_I,
   // Noise shaping bits from the register bank
   input wire logic NOISE_SHAPING_ENABLE_A_I,
   input wire logic NOISE_SHAPING_ENABLE_B_I,
   // Mode and configuration
   output logic PAR_MODE_O,
   output amc_pkg::amc_cfg_t CFG_O,
   // Register bank port
   output logic REG_WR_O,
   output amc_pkg::amc_word_t REG_WORD_O,
   output logic REG_INIT_O,
   output logic READBACK_MODE_O,
   // Readback pin
   output logic READBACK_OUT_PIN_O,
   output logic READBACK_OUT_PIN_OE_O
);
   amc_pkg::amc_top_st_t st_reg;
   amc_pkg::amc_top_st_t st_next;
   amc_pkg::amc_word_t rx_word;
   amc_pkg::amc_cfg_t pin_cfg;
   logic rx_vld;
   logic ser_ok;
   logic hw_init;
   logic gc_hit;
   logic sw_init;

   // Reference from the clock pin level
   function automatic logic ref_internal(input logic [1:0] lvl);
      ref_internal = (lvl == `AMC_LVL_ZERO) || (lvl == `AMC_LVL_FULL);
   endfunction

   // Format and interface from the select pin level
   function automatic logic [1:0] fmt_decode(input logic [1:0] lvl);
      case (lvl)
         `AMC_LVL_ZERO: fmt_decode = 2'h0;
         `AMC_LVL_3_8: fmt_decode = 2'h2;
         `AMC_LVL_5_8: fmt_decode = 2'h3;
         `AMC_LVL_FULL: fmt_decode = 2'h1;
         default: fmt_decode = 2'h0;
      endcase
   endfunction

   // Mode pin code to noise shaping and power fields
   function automatic amc_pkg::amc_cfg_t mp_decode(input logic [2:0] c);
      amc_pkg::amc_cfg_t d;
      d = '0;
      case (c)
         `AMC_MP_NORMAL: d = '0;
         `AMC_MP_NS_B: d.ns_b = 1'b1;
         `AMC_MP_NS_A: d.ns_a = 1'b1;
         `AMC_MP_NS_AB: begin
            d.ns_a = 1'b1;
            d.ns_b = 1'b1;
         end
         `AMC_MP_PDN: d.pwr_down = 1'b1;
         `AMC_MP_STBY_B: d.stby_b = 1'b1;
         default: d = '0; // Unlisted codes run normally
      endcase
      mp_decode = d;
   endfunction

   // Serial receiver; listens only in serial mode with reset pin low
   amc_serial_rx u_rx (
      .clk_i(SYS_CLK_I),
      .nrst_i(NRST_I),
      .en_i(ser_ok),
      .port_select_low_i(PORT_SELECT_LOW_I),
      .shift_clk_i(SHIFT_CLK_I),
      .shift_data_pin_i(SHIFT_DATA_PIN_I),
      .word_vld_o(rx_vld),
      .word_o(rx_word)
   );

   // Qualifiers of the serial path and the init sources
   assign ser_ok = (st_reg.mode == amc_pkg::AMC_SER) && !st_reg.rst_s;
   assign hw_init = st_reg.rst_s &&
      (st_reg.hi_cnt == 8'(`AMC_INIT_MIN_CYC - 1));
   assign gc_hit = ser_ok && rx_vld && (rx_word.addr == `AMC_REG_GLOBAL);
   assign sw_init = gc_hit && rx_word.data[`AMC_GC_INIT];

   // Pin decoded configuration
   always_comb begin
      pin_cfg = mp_decode(st_reg.mp_s);
      if (st_reg.mode == amc_pkg::AMC_PAR) begin
         pin_cfg.int_ref = ref_internal(st_reg.sl_s);
         {pin_cfg.twos_fmt, pin_cfg.cmos_out} =
            fmt_decode(st_reg.pl_s);
      end else begin
         {pin_cfg.int_ref, pin_cfg.twos_fmt, pin_cfg.cmos_out} =
            3'(`AMC_CFG_DEFAULT >> 4);
      end
      // A set register bit overrides the pins
      pin_cfg.ns_a = pin_cfg.ns_a | NOISE_SHAPING_ENABLE_A_I;
      pin_cfg.ns_b = pin_cfg.ns_b | NOISE_SHAPING_ENABLE_B_I;
   end

   // Next state
   always_comb begin
      st_next = st_reg;
      // Two flop synchronisers on every pin
      st_next.rst_m = RST_PIN_I;
      st_next.rst_s = st_reg.rst_m;
      st_next.mp_m = {MODE_PIN_1_I, MODE_PIN_2_I, MODE_PIN_3_I};
      st_next.mp_s = st_reg.mp_m;
      st_next.sl_m = SHIFT_CLK_LVL_I;
      st_next.sl_s = st_reg.sl_m;
      st_next.pl_m = PORT_SELECT_LVL_I;
      st_next.pl_s = st_reg.pl_m;
      // Saturating high time of the reset pin
      if (!st_reg.rst_s) begin
         st_next.hi_cnt = '0;
      end else if (st_reg.hi_cnt != PAR_HOLD_CYC) begin
         st_next.hi_cnt = st_reg.hi_cnt + 8'h01;
      end
      // A long high means parallel pins; a short pulse is only an init
      if (!st_reg.rst_s) begin
         st_next.mode = amc_pkg::AMC_SER;
      end else if (st_reg.hi_cnt == PAR_HOLD_CYC - 8'h01) begin
         st_next.mode = amc_pkg::AMC_PAR;
      end
      st_next.init = hw_init || sw_init;
      // Readback bit cleared by any init and while the reset pin is high, else loaded from register 0
      if (hw_init || sw_init || st_reg.rst_s) begin
         st_next.rdbk = 1'b0;
      end else if (gc_hit) begin
         st_next.rdbk = rx_word.data[`AMC_GC_RDBK];
      end
      // Other addresses pass on; readback mode blocks them
      st_next.wr = ser_ok && rx_vld && !gc_hit && !st_reg.rdbk;
      if (st_next.wr) begin
         st_next.word = rx_word;
      end
      st_next.cfg = pin_cfg;
   end

   // State register; sync reset
   always_ff @(posedge SYS_CLK_I) begin
      if (!NRST_I) begin
         st_reg <= '0;
         st_reg.mode <= amc_pkg::AMC_SER;
         st_reg.cfg <= amc_pkg::amc_cfg_t'(`AMC_CFG_DEFAULT);
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from state
   assign PAR_MODE_O = (st_reg.mode == amc_pkg::AMC_PAR);
   assign CFG_O = st_reg.cfg;
   assign REG_WR_O = st_reg.wr;
   assign REG_WORD_O = st_reg.word;
   assign REG_INIT_O = st_reg.init;
   assign READBACK_MODE_O = st_reg.rdbk;
   // Driven low, never floated; readback shifting is not built
   assign READBACK_OUT_PIN_O = 1'b0;
   assign READBACK_OUT_PIN_OE_O = 1'b1;

   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!NRST_I);

   property p_hw_init;
      $rose(st_reg.rst_s) |=> REG_INIT_O ##1 !REG_INIT_O;
   endproperty
   a_hw_init: assert property (p_hw_init)
      else $error("reset pin pulse gave no single init");
   property p_sw_init;
      sw_init |=> REG_INIT_O && !READBACK_MODE_O && !REG_WR_O;
   endproperty
   a_sw_init: assert property (p_sw_init)
      else $error("init bit did not init and self clear");
   property p_par_entry;
      st_reg.rst_s && st_reg.hi_cnt == PAR_HOLD_CYC - 8'h01
         |=> PAR_MODE_O;
   endproperty
   a_par_entry: assert property (p_par_entry)
      else $error("long reset high did not enter parallel");
   property p_par_exit;
      !st_reg.rst_s |=> !PAR_MODE_O;
   endproperty
   a_par_exit: assert property (p_par_exit)
      else $error("reset pin low left parallel mode on");
   property p_ref;
      PAR_MODE_O && $stable(st_reg.sl_s) |=>
         CFG_O.int_ref == ref_internal($past(st_reg.sl_s));
   endproperty
   a_ref: assert property (p_ref)
      else $error("reference choice wrong");
   property p_fmt;
      PAR_MODE_O && st_reg.pl_s == `AMC_LVL_5_8 |=>
         CFG_O.twos_fmt && CFG_O.cmos_out;
   endproperty
   a_fmt: assert property (p_fmt)
      else $error("format or interface wrong");
   property p_pdn;
      st_reg.mp_s == `AMC_MP_PDN |=> CFG_O.pwr_down && !CFG_O.stby_b;
   endproperty
   a_pdn: assert property (p_pdn)
      else $error("power down code not decoded");
   property p_no_wr_par;
      PAR_MODE_O |=> !REG_WR_O && !REG_INIT_O;
   endproperty
   a_no_wr_par: assert property (p_no_wr_par)
      else $error("register access in parallel mode");
   property p_wr_word;
      ser_ok && rx_vld && !gc_hit && !READBACK_MODE_O |=>
         REG_WR_O && REG_WORD_O == $past(rx_word);
   endproperty
   a_wr_word: assert property (p_wr_word)
      else $error("serial word not forwarded");
   property p_pin_low;
      READBACK_OUT_PIN_OE_O && !READBACK_OUT_PIN_O;
   endproperty
   a_pin_low: assert property (p_pin_low)
      else $error("readback pin not driven low");

   // Serial and combined modes keep format and reference at defaults
   property p_ser_cfg;
      !PAR_MODE_O |=> CFG_O.int_ref && !CFG_O.twos_fmt && !CFG_O.cmos_out;
   endproperty
   a_ser_cfg: assert property (p_ser_cfg)
      else $error("serial mode format not at register default");
   // Second select level: twos complement on the LVDS bus
   property p_fmt_lvds;
      PAR_MODE_O && st_reg.pl_s == `AMC_LVL_3_8 |=>
         CFG_O.twos_fmt && !CFG_O.cmos_out;
   endproperty
   a_fmt_lvds: assert property (p_fmt_lvds)
      else $error("twos complement LVDS level misdecoded");
   property p_ns_both;
      st_reg.mp_s == `AMC_MP_NS_AB |=> CFG_O.ns_a && CFG_O.ns_b;
   endproperty
   a_ns_both: assert property (p_ns_both)
      else $error("noise shaping code for both channels misdecoded");
   // A set register bit always wins, so pins rule only when bits are 0
   property p_ns_reg_a;
      NOISE_SHAPING_ENABLE_A_I |=> CFG_O.ns_a;
   endproperty
   a_ns_reg_a: assert property (p_ns_reg_a)
      else $error("channel A register enable not honoured");
   property p_ns_reg_b;
      NOISE_SHAPING_ENABLE_B_I |=> CFG_O.ns_b;
   endproperty
   a_ns_reg_b: assert property (p_ns_reg_b)
      else $error("channel B register enable not honoured");
   // Init lasts one cycle; the bank sees the bit as already cleared
   property p_init_pulse;
      REG_INIT_O |=> !REG_INIT_O;
   endproperty
   a_init_pulse: assert property (p_init_pulse)
      else $error("init pulse longer than one cycle");
   // No register write reaches the bank while the reset pin is high
   property p_no_wr_rst;
      st_reg.rst_s |=> !REG_WR_O;
   endproperty
   a_no_wr_rst: assert property (p_no_wr_rst)
      else $error("register write while reset pin high");
   // Readback mode shuts the bank off from other addresses
   property p_rdbk_block;
      READBACK_MODE_O |=> !REG_WR_O;
   endproperty
   a_rdbk_block: assert property (p_rdbk_block)
      else $error("register write while readback mode set");

   c_par: cover property (PAR_MODE_O);
   c_sw_init: cover property (sw_init);
   c_wr: cover property (REG_WR_O);
   c_rdbk: cover property (READBACK_MODE_O ##[1:500] !READBACK_MODE_O);
endmodule

// ### tb/amc_ctrl_model.sv
// Model of the external controller that drives the serial config pins.
// Assumes the bench calls send from one thread; pins idle between frames.
`timescale 1ns/1ns
module amc_ctrl_model (
   // Serial port pins towards the device
   output logic sel_n_o,
   output logic sclk_o,
   output logic shift_data_pin_o
);
   // Idle: deselected, clock parked high, data low
   initial begin
      sel_n_o = 1'b1;
      sclk_o = 1'b1;
      shift_data_pin_o = 1'b0;
   end

   // Shifts the low nb bits of v, MSB first; th/tl are clock high/low ns
   task automatic send(input logic [47:0] v, input int nb, input int th,
                       input int tl);
      #7; // Phase unrelated to the system clock
      sel_n_o = 1'b0;
      #th;
      for (int i = nb - 1; i >= 0; i--) begin
         shift_data_pin_o = v[i];
         sclk_o = 1'b1;
         #th;
         sclk_o = 1'b0;
         #tl;
      end
      sclk_o = 1'b1;
      #th;
      sel_n_o = 1'b1;
      // Released line must not look like held data
      shift_data_pin_o = ~shift_data_pin_o;
   endtask

   // Data line parked low while pins alone configure
   task automatic idle_low;
      shift_data_pin_o = 1'b0;
   endtask
endmodule

// ### tb/test_amc_cfg_top.sv
// Bench of the config front end: parallel decode and serial writes.
// Assumes hdl/ compiled first; serial pins come from amc_ctrl_model.
`timescale 1ns/1ns
module test_amc_cfg_top;
   logic clk, nrst, rst_pin, sel_n, sclk, sdat, nsa, nsb;
   logic [2:0] mp;
   logic [1:0] sl, pl;
   logic par, wr, init, rdbk, rb_pin, rb_oe;
   amc_pkg::amc_cfg_t cfg;
   amc_pkg::amc_word_t word;
   logic [16:0] notes[$];
   logic [16:0] nt;
   logic [31:0] rv;
   logic [31:0] rs = 32'h000118B1;
   int error_cnt = 0;
   int total_checks = 0;

   amc_cfg_top #(.PAR_HOLD_CYC(8'h04)) i_dut (
      .SYS_CLK_I(clk), .NRST_I(nrst), .RST_PIN_I(rst_pin),
      .MODE_PIN_1_I(mp[2]), .MODE_PIN_2_I(mp[1]), .MODE_PIN_3_I(mp[0]),
      .PORT_SELECT_LOW_I(sel_n), .SHIFT_CLK_I(sclk),
      .SHIFT_DATA_PIN_I(sdat), .SHIFT_CLK_LVL_I(sl),
      .PORT_SELECT_LVL_I(pl), .NOISE_SHAPING_ENABLE_A_I(nsa),
      .NOISE_SHAPING_ENABLE_B_I(nsb), .PAR_MODE_O(par), .CFG_O(cfg),
      .REG_WR_O(wr), .REG_WORD_O(word), .REG_INIT_O(init),
      .READBACK_MODE_O(rdbk), .READBACK_OUT_PIN_O(rb_pin),
      .READBACK_OUT_PIN_OE_O(rb_oe));

   amc_ctrl_model i_ctrl (.sel_n_o(sel_n), .sclk_o(sclk), .shift_data_pin_o(sdat));

   // 50 MHz system clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction

   // Random word whose address is never the global control register
   function automatic logic [15:0] rw();
      logic [31:0] r;
      r = xs();
      return {r[15:8] | 8'h01, r[7:0]};
   endfunction

   function automatic amc_pkg::amc_cfg_t cfg_exp(input logic p,
      input logic [1:0] s, l, input logic [2:0] c, input logic a, b);
      amc_pkg::amc_cfg_t e;
      e.int_ref = p ? (s == 2'h0 || s == 2'h3) : 1'b1;
      e.twos_fmt = p & (l == 2'h1 || l == 2'h2);
      e.cmos_out = p & l[1];
      e.ns_a = (c == 3'h2 || c == 3'h3) | a;
      e.ns_b = (c == 3'h1 || c == 3'h3) | b;
      e.pwr_down = (c == 3'h4);
      e.stby_b = (c == 3'h5);
      return e;
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Sets level and mode pins, lets the decode settle, compares
   task automatic setchk(input logic p, input logic [1:0] s, l,
                         input logic [2:0] c, input logic a, b);
      @(negedge clk);
      sl = s;
      pl = l;
      mp = c;
      nsa = a;
      nsb = b;
      repeat (6) @(negedge clk);
      chk(32'(cfg), 32'(cfg_exp(p, s, l, c, a, b)));
   endtask

   // One select-low frame; notes each whole word when a write is due
   task automatic frame(input logic [47:0] v, input int nb, input int th,
                        input int tl, input bit ex);
      for (int k = 0; k < nb / 16; k++) begin
         if (ex) begin
            notes.push_back({1'b0, v[nb - 1 - 16 * k -: 16]});
         end
      end
      i_ctrl.send(v, nb, th, tl);
      repeat (12) @(negedge clk);
   endtask

   // Pops the oldest note whenever the bank port pulses
   always @(negedge clk) begin
      if (wr === 1'b1 || init === 1'b1) begin
         nt = (notes.size() > 0) ? notes.pop_front() : 17'h1FFFF;
         chk(32'({init, init ? 16'h0000 : word}), 32'(nt));
      end
   end

   // Hang guard, well beyond the expected run length
   initial begin
      #400000;
      error_cnt++;
      end_of_test;
   end

   initial begin
      nrst = 1'b0;
      rst_pin = 1'b0;
      mp = 3'h0;
      sl = 2'h0;
      pl = 2'h0;
      nsa = 1'b0;
      nsb = 1'b0;
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      chk(32'(cfg),
         32'(cfg_exp(1'b0, 2'h0, 2'h0, 3'h0, 1'b0, 1'b0)));
      chk(32'(par), 32'h0);
      chk(32'({rb_pin, rb_oe}), 32'h1);
      repeat (6) @(negedge clk);
      // Registers reset first by a short pin pulse
      notes.push_back(17'h10000);
      rst_pin = 1'b1;
      repeat (2) @(negedge clk);
      rst_pin = 1'b0;
      repeat (10) @(negedge clk);
      $display("test init pulse done");
      // Single, chained, partial and slow words
      frame({32'h0, rw()}, 16, 80, 80, 1'b1);
      frame({rw(), rw(), rw()}, 48, 80, 80, 1'b1);
      frame({27'h0, rw(), 5'h15}, 21, 80, 80, 1'b1);
      frame({32'h0, rw()}, 16, 100, 420, 1'b1);
      $display("test serial words done");
      // Readback bit blocks writes; software init clears it
      frame({32'h0, 16'h0001}, 16, 80, 80, 1'b0);
      chk(32'(rdbk), 32'h1);
      frame({32'h0, rw()}, 16, 80, 80, 1'b0);
      // Init and readback set in one word: init must win
      notes.push_back(17'h10000);
      frame({32'h0, 16'h0081}, 16, 80, 80, 1'b0);
      chk(32'(rdbk), 32'h0);
      $display("test global control done");
      // Mode pins decode in serial mode, register bits OR in
      for (int i = 0; i < 8; i++) begin
         rv = xs();
         setchk(1'b0, rv[3:2], rv[5:4], 3'(i), rv[0], rv[1]);
      end
      $display("test serial mode pins done");
      // Parallel mode: reset pin held high
      notes.push_back(17'h10000);
      i_ctrl.idle_low;
      @(negedge clk);
      rst_pin = 1'b1;
      repeat (20) @(negedge clk);
      chk(32'(par), 32'h1);
      for (int i = 0; i < 16; i++) begin
         rv = xs();
         setchk(1'b1, 2'(i >> 2), 2'(i), rv[2:0], 1'b0, 1'b0);
      end
      rst_pin = 1'b0;
      repeat (6) @(negedge clk);
      chk(32'(par), 32'h0);
      chk(32'(notes.size()), 32'h0);
      $display("test parallel mode done");
      end_of_test;
   end
endmodule
